// ===== core/cid_core.sv
// instruction execution slice with a classic wishbone register port
// assumes a single-master classic bus on the core clock
`timescale 1ns/1ps
module cid_core (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O
);
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [7:0] file_mem [cid_pkg::FILE_DEPTH];
    logic [cid_pkg::PC_W-1:0] stack_mem [cid_pkg::STACK_DEPTH];

    cid_pkg::cid_state_e state, next_state;
    logic [10:0] instr, next_instr;
    logic [7:0] working_accumulator, next_working_accumulator;
    logic [cid_pkg::LATCH_W-1:0] pc_high_latch, next_pc_high_latch;
    logic [cid_pkg::PC_W-1:0] pc, next_pc;
    logic [cid_pkg::SP_W-1:0] sp, next_sp;
    logic zero_flag, next_zero_flag;
    logic timeout_flag, next_timeout_flag;
    logic powerdown_flag, next_powerdown_flag;
    logic skipped, next_skipped;
    logic [cid_pkg::WDT_W-1:0] watchdog_counter, next_watchdog_counter;
    logic [cid_pkg::PRE_W-1:0] prescale, next_prescale;
    logic [6:0] file_addr, next_file_addr;
    logic [31:0] next_dat;
    logic next_ack;
    logic file_we;
    logic [6:0] file_wa;
    logic [7:0] file_wd;
    logic stack_we;

    logic bus_req, bus_wr;
    logic [5:0] widx;
    logic [2:0] op;
    logic dest_file;
    logic [6:0] f_addr;
    logic [7:0] alu_result;
    logic alu_wr_file, alu_wr_acc, alu_zero_upd, alu_zero;
    logic exec;
    logic [cid_pkg::PC_W-1:0] stack_top;
    logic [31:0] wmerge;

    assign bus_req = CYC_I & STB_I & ~ACK_O;
    // writes land at the edge where the master samples ack, not at the taking edge
    assign bus_wr = CYC_I & STB_I & WE_I & ACK_O;
    assign widx = ADR_I[7:2];
    assign op = instr[cid_pkg::INSTR_OP_LSB +: cid_pkg::INSTR_OP_W];
    assign dest_file = instr[cid_pkg::INSTR_D_BIT];
    assign f_addr = instr[cid_pkg::INSTR_F_LSB +: cid_pkg::INSTR_F_W];
    assign exec = (state == cid_pkg::ST_EXEC);
    assign stack_top = stack_mem[4'(sp - 4'h1)];

    cid_alu u_alu (
        .op_i(op),
        .dest_file_i(dest_file),
        .file_i(file_mem[f_addr]),
        .result_o(alu_result),
        .wr_file_o(alu_wr_file),
        .wr_acc_o(alu_wr_acc),
        .zero_upd_o(alu_zero_upd),
        .zero_o(alu_zero)
    );

    always_comb begin
        wmerge = 32'h0;
        next_state = state;
        next_instr = instr;
        next_working_accumulator = working_accumulator;
        next_pc_high_latch = pc_high_latch;
        next_pc = pc;
        next_sp = sp;
        next_zero_flag = zero_flag;
        next_timeout_flag = timeout_flag;
        next_powerdown_flag = powerdown_flag;
        next_skipped = skipped;
        next_file_addr = file_addr;
        file_we = 1'b0;
        file_wa = f_addr;
        file_wd = alu_result;
        stack_we = 1'b0;
        // free-running watchdog; overflow marks a timeout
        next_prescale = 8'(prescale + 8'h01);
        next_watchdog_counter = watchdog_counter;
        if (prescale == 8'hff) begin
            next_watchdog_counter = 16'(watchdog_counter + 16'h0001);
            if (watchdog_counter == 16'hffff) begin
                next_timeout_flag = 1'b0;
            end
        end
        // bus writes first so that execution overrides them
        if (bus_wr) begin
            case (widx)
                cid_pkg::REG_INSTR: begin
                    // new instruction refused while busy
                    if (state == cid_pkg::ST_IDLE) begin
                        wmerge = lane_merge({21'h0, instr}, DAT_I, SEL_I);
                        next_instr = wmerge[10:0];
                        next_state = cid_pkg::ST_EXEC;
                    end
                end
                cid_pkg::REG_ACC: begin
                    wmerge = lane_merge({24'h0, working_accumulator}, DAT_I, SEL_I);
                    next_working_accumulator = wmerge[7:0];
                end
                cid_pkg::REG_LATCH: begin
                    wmerge = lane_merge({25'h0, pc_high_latch}, DAT_I, SEL_I);
                    next_pc_high_latch = wmerge[6:0];
                end
                cid_pkg::REG_PC: begin
                    wmerge = lane_merge({17'h0, pc}, DAT_I, SEL_I);
                    next_pc = wmerge[14:0];
                end
                cid_pkg::REG_STATUS: begin
                    if (SEL_I[0]) begin
                        next_zero_flag = DAT_I[cid_pkg::ST_ZERO_BIT];
                        next_powerdown_flag = DAT_I[cid_pkg::ST_POWERDOWN_BIT];
                    end
                end
                cid_pkg::REG_FILE_ADDR: begin
                    if (SEL_I[0]) begin
                        next_file_addr = DAT_I[6:0];
                    end
                end
                cid_pkg::REG_FILE_DATA: begin
                    if (SEL_I[0]) begin
                        file_we = 1'b1;
                        file_wa = file_addr;
                        file_wd = DAT_I[7:0];
                    end
                end
                default: begin
                    next_file_addr = file_addr;
                end
            endcase
        end
        case (state)
            cid_pkg::ST_IDLE: begin
                next_skipped = skipped;
            end
            cid_pkg::ST_EXEC: begin
                next_state = cid_pkg::ST_IDLE;
                next_pc = 15'(pc + 15'h0001);
                next_skipped = 1'b0;
                if (alu_wr_file) begin
                    file_we = 1'b1;
                    file_wa = f_addr;
                    file_wd = alu_result;
                end
                if (alu_wr_acc) begin
                    next_working_accumulator = alu_result;
                end
                if (alu_zero_upd) begin
                    next_zero_flag = alu_zero;
                end
                case (op)
                    cid_pkg::OP_WDT_CLEAR: begin
                        next_watchdog_counter = cid_pkg::WDT_CLEAR_VAL;
                        next_prescale = cid_pkg::PRE_CLEAR_VAL;
                        // set wins over a coincident overflow
                        next_timeout_flag = 1'b1;
                        next_powerdown_flag = 1'b1;
                    end
                    cid_pkg::OP_CALL_ACC: begin
                        // stack wraps when full, oldest entry lost
                        stack_we = 1'b1;
                        next_sp = 4'(sp + 4'h1);
                        next_pc = {pc_high_latch, working_accumulator};
                        next_state = cid_pkg::ST_NOP;
                    end
                    cid_pkg::OP_DEC_SKIP: begin
                        if (alu_zero) begin
                            // fetched successor discarded, nop runs instead
                            next_pc = 15'(pc + 15'h0002);
                            next_skipped = 1'b1;
                            next_state = cid_pkg::ST_NOP;
                        end
                    end
                    default: begin
                        next_skipped = 1'b0;
                    end
                endcase
            end
            cid_pkg::ST_NOP: begin
                next_state = cid_pkg::ST_IDLE;
            end
            default: begin
                next_state = cid_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb begin
        next_ack = bus_req;
        next_dat = 32'h0;
        if (bus_req && !WE_I) begin
            case (widx)
                cid_pkg::REG_INSTR: next_dat = {21'h0, instr};
                cid_pkg::REG_ACC: next_dat = {24'h0, working_accumulator};
                cid_pkg::REG_LATCH: next_dat = {25'h0, pc_high_latch};
                cid_pkg::REG_PC: next_dat = {17'h0, pc};
                cid_pkg::REG_STATUS: next_dat = {27'h0, skipped, (state != cid_pkg::ST_IDLE),
                                                  powerdown_flag, timeout_flag, zero_flag};
                cid_pkg::REG_WDT: next_dat = {16'h0, watchdog_counter};
                cid_pkg::REG_PRESCALE: next_dat = {24'h0, prescale};
                cid_pkg::REG_STACK_TOP: next_dat = {17'h0, stack_top};
                cid_pkg::REG_FILE_ADDR: next_dat = {25'h0, file_addr};
                cid_pkg::REG_FILE_DATA: next_dat = {24'h0, file_mem[file_addr]};
                default: next_dat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            state <= cid_pkg::ST_IDLE;
            instr <= 11'h000;
            working_accumulator <= cid_pkg::ACC_RST;
            pc_high_latch <= cid_pkg::LATCH_RST;
            pc <= cid_pkg::PC_RST;
            sp <= 4'h0;
            zero_flag <= 1'b0;
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
            skipped <= 1'b0;
            watchdog_counter <= cid_pkg::WDT_CLEAR_VAL;
            prescale <= cid_pkg::PRE_CLEAR_VAL;
            file_addr <= 7'h00;
            DAT_O <= 32'h0;
            ACK_O <= 1'b0;
        end else begin
            state <= next_state;
            instr <= next_instr;
            working_accumulator <= next_working_accumulator;
            pc_high_latch <= next_pc_high_latch;
            pc <= next_pc;
            sp <= next_sp;
            zero_flag <= next_zero_flag;
            timeout_flag <= next_timeout_flag;
            powerdown_flag <= next_powerdown_flag;
            skipped <= next_skipped;
            watchdog_counter <= next_watchdog_counter;
            prescale <= next_prescale;
            file_addr <= next_file_addr;
            DAT_O <= next_dat;
            ACK_O <= next_ack;
        end
    end

    // memories carry no reset; contents are software's job
    always_ff @(posedge CLK_I) begin
        if (file_we) begin
            file_mem[file_wa] <= file_wd;
        end
        if (stack_we) begin
            stack_mem[sp] <= 15'(pc + 15'h0001);
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    sequence s_exec_op(logic [2:0] o);
        exec && op == o;
    endsequence
    sequence s_two_cycle;
        state == cid_pkg::ST_NOP ##1 state == cid_pkg::ST_IDLE;
    endsequence

    a_wdt_clear_flags: assert property (s_exec_op(cid_pkg::OP_WDT_CLEAR) |=>
        watchdog_counter == 16'h0000 && timeout_flag && powerdown_flag)
        else $error("watchdog clear did not zero counter or set flags");
    a_prescale_cleared: assert property (s_exec_op(cid_pkg::OP_WDT_CLEAR) |=>
        prescale == 8'h00 ##1 prescale == 8'h01)
        else $error("prescaler not restarted from zero");
    a_call_push: assert property (s_exec_op(cid_pkg::OP_CALL_ACC) |=>
        stack_top == 15'($past(pc) + 15'h0001) && sp == 4'($past(sp) + 4'h1))
        else $error("return address not pushed");
    a_call_load_pc: assert property (s_exec_op(cid_pkg::OP_CALL_ACC) |=>
        pc == {$past(pc_high_latch), $past(working_accumulator)})
        else $error("call target wrong");
    a_call_two_cycle: assert property (s_exec_op(cid_pkg::OP_CALL_ACC) |=>
        s_two_cycle and $stable(zero_flag))
        else $error("call not two cycles or flags changed");
    a_compl_result: assert property ((s_exec_op(cid_pkg::OP_COMPL_FILE) and !dest_file) |=>
        working_accumulator == ~$past(file_mem[f_addr]) && zero_flag == (working_accumulator == 8'h00))
        else $error("complement result wrong");
    a_dest_file: assert property ((s_exec_op(cid_pkg::OP_DEC_FILE) and dest_file) |=>
        file_mem[$past(f_addr)] == 8'($past(alu_result)) && $stable(working_accumulator))
        else $error("file destination not honoured");
    a_clear_file: assert property (s_exec_op(cid_pkg::OP_CLEAR_FILE) |=>
        file_mem[$past(f_addr)] == 8'h00 && zero_flag)
        else $error("clear file wrong");
    a_dec_zero: assert property (s_exec_op(cid_pkg::OP_DEC_FILE) |=>
        zero_flag == ($past(file_mem[f_addr]) == 8'h01))
        else $error("decrement zero flag wrong");
    a_clear_acc: assert property (s_exec_op(cid_pkg::OP_CLEAR_ACC) |=>
        working_accumulator == 8'h00 && zero_flag)
        else $error("clear accumulator wrong");
    a_skip_flags: assert property (s_exec_op(cid_pkg::OP_DEC_SKIP) |=>
        $stable(zero_flag) && $stable(timeout_flag))
        else $error("decrement-skip touched flags");
    a_skip_nop: assert property ((s_exec_op(cid_pkg::OP_DEC_SKIP) and alu_zero) |=>
        s_two_cycle and pc == 15'($past(pc) + 15'h0002))
        else $error("skip did not insert nop");
    a_no_skip: assert property ((s_exec_op(cid_pkg::OP_DEC_SKIP) and !alu_zero) |=>
        state == cid_pkg::ST_IDLE && pc == 15'($past(pc) + 15'h0001))
        else $error("non-zero result skipped");
endmodule

// ===== core/cid_pkg.sv
// constants, opcodes and register map for the clear/decrement/call instruction slice
// assumes a 10 MHz core clock where one instruction cycle is one clock
package cid_pkg;
    localparam int PC_W = 15;
    localparam int LATCH_W = 7;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = 4;
    localparam int FILE_DEPTH = 128;
    localparam int WDT_W = 16;
    localparam int PRE_W = 8;

    // instruction word layout
    localparam int INSTR_F_LSB = 0;
    localparam int INSTR_F_W = 7;
    localparam int INSTR_D_BIT = 7;
    localparam int INSTR_OP_LSB = 8;
    localparam int INSTR_OP_W = 3;

    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_WDT_CLEAR = 3'h1,
        OP_CALL_ACC = 3'h2,
        OP_COMPL_FILE = 3'h3,
        OP_CLEAR_FILE = 3'h4,
        OP_DEC_FILE = 3'h5,
        OP_CLEAR_ACC = 3'h6,
        OP_DEC_SKIP = 3'h7
    } cid_op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_NOP = 3'b100
    } cid_state_e;

    // word indices (byte address bits 7:2)
    localparam logic [5:0] REG_INSTR = 6'h00;
    localparam logic [5:0] REG_ACC = 6'h01;
    localparam logic [5:0] REG_LATCH = 6'h02;
    localparam logic [5:0] REG_PC = 6'h03;
    localparam logic [5:0] REG_STATUS = 6'h04;
    localparam logic [5:0] REG_WDT = 6'h05;
    localparam logic [5:0] REG_PRESCALE = 6'h06;
    localparam logic [5:0] REG_STACK_TOP = 6'h07;
    localparam logic [5:0] REG_FILE_ADDR = 6'h08;
    localparam logic [5:0] REG_FILE_DATA = 6'h09;

    // status bit positions
    localparam int ST_ZERO_BIT = 0;
    localparam int ST_TIMEOUT_BIT = 1;
    localparam int ST_POWERDOWN_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_SKIPPED_BIT = 4;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    localparam logic [WDT_W-1:0] WDT_CLEAR_VAL = 16'h0000;
    localparam logic [PRE_W-1:0] PRE_CLEAR_VAL = 8'h00;
endpackage

// ===== core/cid_alu.sv
// combinational result unit for the file and accumulator operations
// assumes operands are stable for the whole execute cycle
`timescale 1ns/1ps
module cid_alu (
    input wire logic [2:0] op_i,
    input wire logic dest_file_i,
    input wire logic [7:0] file_i,
    output logic [7:0] result_o,
    output logic wr_file_o,
    output logic wr_acc_o,
    output logic zero_upd_o,
    output logic zero_o
);
    always_comb begin
        result_o = 8'h00;
        wr_file_o = 1'b0;
        wr_acc_o = 1'b0;
        zero_upd_o = 1'b0;
        case (op_i)
            cid_pkg::OP_COMPL_FILE: begin
                result_o = ~file_i;
                wr_file_o = dest_file_i;
                wr_acc_o = ~dest_file_i;
                zero_upd_o = 1'b1;
            end
            cid_pkg::OP_CLEAR_FILE: begin
                result_o = 8'h00;
                wr_file_o = 1'b1;
                zero_upd_o = 1'b1;
            end
            cid_pkg::OP_DEC_FILE, cid_pkg::OP_DEC_SKIP: begin
                result_o = 8'(file_i - 8'h01);
                wr_file_o = dest_file_i;
                wr_acc_o = ~dest_file_i;
                // skip form leaves flags alone
                zero_upd_o = (op_i == cid_pkg::OP_DEC_FILE);
            end
            cid_pkg::OP_CLEAR_ACC: begin
                result_o = 8'h00;
                wr_acc_o = 1'b1;
                zero_upd_o = 1'b1;
            end
            default: begin
                result_o = 8'h00;
            end
        endcase
    end

    assign zero_o = (result_o == 8'h00);
endmodule

// ===== tb/core_instr_clear_dec_call_exec_tb.sv
// self-checking bench for the clear/decrement/call instruction slice
// assumes the slice is reached only through its classic wishbone register port
`timescale 1ns/1ps
module core_instr_clear_dec_call_exec_tb;
    logic CLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic CYC_I = 1'b0;
    logic STB_I = 1'b0;
    logic WE_I = 1'b0;
    logic [7:0] ADR_I = 8'h00;
    logic [3:0] SEL_I = 4'h0;
    logic [31:0] DAT_I = 32'h00000000;
    logic [31:0] DAT_O;
    logic ACK_O;
    int err_total = 0;
    int compares = 0;

    cid_core DUT (.CLK_I(CLK_I), .RESET_I(RESET_I), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
        .ACK_O(ACK_O));

    initial begin
        forever #50 CLK_I = ~CLK_I;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; request held until ack is sampled, then one idle cycle
    task automatic wb_cycle(input logic we, input logic [5:0] idx, input logic [31:0] wdat,
                            output logic [31:0] rdat);
        int n;
        n = 0;
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= we;
        ADR_I <= {idx, 2'b00};
        SEL_I <= 4'hf;
        DAT_I <= wdat;
        do begin
            @(posedge CLK_I);
            n++;
        end while (ACK_O !== 1'b1 && n < 50);
        rdat = DAT_O;
        if (ACK_O !== 1'b1) begin
            err_total++;
            $display("mismatch ack expected 1 seen %b", ACK_O);
            complete_run();
        end
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I <= 1'b0;
        @(posedge CLK_I);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] wdat);
        logic [31:0] unused;
        wb_cycle(1'b1, idx, wdat, unused);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] rdat);
        wb_cycle(1'b0, idx, 32'h00000000, rdat);
    endtask

    task automatic rd_chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        rd(idx, v);
        check(what, exp, v);
    endtask

    // busy is polled rather than counted, so call and skip need no special wait
    task automatic exec(input cid_pkg::cid_op_e op, input logic d, input logic [6:0] f);
        logic [31:0] st;
        int n;
        n = 0;
        wr(cid_pkg::REG_INSTR, {21'h000000, op, d, f});
        do begin
            rd(cid_pkg::REG_STATUS, st);
            n++;
        end while (st[cid_pkg::ST_BUSY_BIT] !== 1'b0 && n < 20);
        if (st[cid_pkg::ST_BUSY_BIT] !== 1'b0) begin
            err_total++;
            $display("mismatch busy expected 0 seen %b", st[cid_pkg::ST_BUSY_BIT]);
            complete_run();
        end
    endtask

    task automatic set_file(input logic [6:0] f, input logic [7:0] v);
        wr(cid_pkg::REG_FILE_ADDR, {25'h0000000, f});
        wr(cid_pkg::REG_FILE_DATA, {24'h000000, v});
    endtask

    task automatic test_reset();
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000006);
        rd_chk("acc", cid_pkg::REG_ACC, 32'h00000000);
        rd_chk("pc", cid_pkg::REG_PC, 32'h00000000);
        rd_chk("unmapped", 6'h0a, 32'h00000000);
        $display("test reset done");
    endtask

    task automatic test_wdt_clear();
        logic [31:0] v;
        repeat (300) @(posedge CLK_I);
        wr(cid_pkg::REG_STATUS, 32'h00000000);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000002);
        rd(cid_pkg::REG_WDT, v);
        check("watchdog ran", 32'h00000001, {31'h0, v != 32'h0});
        exec(cid_pkg::OP_WDT_CLEAR, 1'b0, 7'h00);
        rd_chk("watchdog", cid_pkg::REG_WDT, 32'h00000000);
        rd(cid_pkg::REG_PRESCALE, v);
        check("prescaler small", 32'h00000001, {31'h0, v < 32'h20});
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000006);
        $display("test watchdog clear done");
    endtask

    task automatic test_compl();
        set_file(7'h05, 8'hff);
        exec(cid_pkg::OP_COMPL_FILE, 1'b0, 7'h05);
        rd_chk("acc", cid_pkg::REG_ACC, 32'h00000000);
        rd_chk("file", cid_pkg::REG_FILE_DATA, 32'h000000ff);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000007);
        set_file(7'h7f, 8'h5a);
        exec(cid_pkg::OP_COMPL_FILE, 1'b1, 7'h7f);
        rd_chk("file", cid_pkg::REG_FILE_DATA, 32'h000000a5);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000006);
        $display("test complement done");
    endtask

    task automatic test_clears();
        set_file(7'h11, 8'h33);
        exec(cid_pkg::OP_CLEAR_FILE, 1'b1, 7'h11);
        rd_chk("file", cid_pkg::REG_FILE_DATA, 32'h00000000);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000007);
        wr(cid_pkg::REG_ACC, 32'h00000077);
        wr(cid_pkg::REG_STATUS, 32'h00000004);
        exec(cid_pkg::OP_CLEAR_ACC, 1'b0, 7'h00);
        rd_chk("acc", cid_pkg::REG_ACC, 32'h00000000);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000007);
        $display("test clears done");
    endtask

    task automatic test_dec();
        wr(cid_pkg::REG_STATUS, 32'h00000004);
        set_file(7'h20, 8'h01);
        exec(cid_pkg::OP_DEC_FILE, 1'b0, 7'h20);
        rd_chk("acc", cid_pkg::REG_ACC, 32'h00000000);
        rd_chk("file", cid_pkg::REG_FILE_DATA, 32'h00000001);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000007);
        set_file(7'h21, 8'h00);
        exec(cid_pkg::OP_DEC_FILE, 1'b1, 7'h21);
        rd_chk("file", cid_pkg::REG_FILE_DATA, 32'h000000ff);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000006);
        $display("test decrement done");
    endtask

    task automatic test_call();
        wr(cid_pkg::REG_STATUS, 32'h00000005);
        wr(cid_pkg::REG_ACC, 32'h000000c3);
        wr(cid_pkg::REG_LATCH, 32'h0000005a);
        wr(cid_pkg::REG_PC, 32'h00001234);
        exec(cid_pkg::OP_CALL_ACC, 1'b0, 7'h00);
        rd_chk("stack top", cid_pkg::REG_STACK_TOP, 32'h00001235);
        rd_chk("pc", cid_pkg::REG_PC, 32'h00005ac3);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000007);
        $display("test call done");
    endtask

    task automatic test_dec_skip();
        wr(cid_pkg::REG_STATUS, 32'h00000005);
        wr(cid_pkg::REG_PC, 32'h00000010);
        set_file(7'h30, 8'h02);
        exec(cid_pkg::OP_DEC_SKIP, 1'b1, 7'h30);
        rd_chk("file", cid_pkg::REG_FILE_DATA, 32'h00000001);
        rd_chk("pc", cid_pkg::REG_PC, 32'h00000011);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000007);
        wr(cid_pkg::REG_STATUS, 32'h00000004);
        exec(cid_pkg::OP_DEC_SKIP, 1'b0, 7'h30);
        rd_chk("acc", cid_pkg::REG_ACC, 32'h00000000);
        rd_chk("file", cid_pkg::REG_FILE_DATA, 32'h00000001);
        rd_chk("pc", cid_pkg::REG_PC, 32'h00000013);
        rd_chk("status", cid_pkg::REG_STATUS, 32'h00000016);
        $display("test decrement skip done");
    endtask

    initial begin
        repeat (3) @(posedge CLK_I);
        RESET_I <= 1'b0;
        @(posedge CLK_I);
        test_reset();
        test_wdt_clear();
        test_compl();
        test_clears();
        test_dec();
        test_call();
        test_dec_skip();
        complete_run();
    end
endmodule
